// *** src/stub_top.sv ***
/*
  Two independent sync trigger generators with upstream buffers, command
  decode of buffer resets and an inter-channel delay for timer mode.
  Assumes control ports are driven by the SPI register logic on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module stub_top
  import stub_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire stub_pkg::stub_src_t src_sel_ch1,
  input wire stub_pkg::stub_src_t src_sel_ch2,
  input wire logic src_sel_wr,
  input wire logic [1:0] encoding_method_select,
  input wire logic [stub_pkg::TMR_W-1:0] sync_interval_timer_reg_ch1,
  input wire logic [stub_pkg::TMR_W-1:0] sync_interval_timer_reg_ch2,
  input wire logic [stub_pkg::DLY_W-1:0] interchannel_trigger_delay,
  input wire logic [1:0] spi_sync_cmd,
  input wire logic [1:0] spi_sync_long,
  input wire logic ext_trigger_pin_ch1,
  input wire logic ext_trigger_pin_ch2,
  input wire logic [1:0] upstream_wr,
  input wire logic [63:0] upstream_wdata,
  input wire logic [stub_pkg::UP_CNT_W-1:0] upstream_len,
  input wire logic [1:0] upstream_confirm,
  input wire logic device_command_wr,
  input wire logic [15:0] device_command_reg,
  input wire logic [1:0] upstream_fault_clr,
  output logic [1:0] sync_trigger,
  output logic [1:0] sync_trigger_long,
  output logic [1:0] upstream_in_progress,
  output logic [1:0] upstream_overrun_fault
);
  import stub_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // source selection and pin synchronisers
  stub_src_t src1, src2, next_src1, next_src2;
  logic [2:0] pin1_sync, pin2_sync, next_pin1_sync, next_pin2_sync;
  logic pin1, pin2, next_pin1, next_pin2;

  always_comb begin
    next_src1 = src1;
    next_src2 = src2;
    if (src_sel_wr) begin
      next_src1 = src_sel_ch1;
      next_src2 = src_sel_ch2;
    end
    next_pin1_sync = {pin1_sync[1:0], ext_trigger_pin_ch1};
    next_pin2_sync = {pin2_sync[1:0], ext_trigger_pin_ch2};
    // a change counts only once stages two and three agree
    next_pin1 = (pin1_sync[2] == pin1_sync[1]) ? pin1_sync[2] : pin1;
    next_pin2 = (pin2_sync[2] == pin2_sync[1]) ? pin2_sync[2] : pin2;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      src1 <= SRC_RESET;
      src2 <= SRC_RESET;
      pin1_sync <= 3'h0;
      pin2_sync <= 3'h0;
      pin1 <= 1'b0;
      pin2 <= 1'b0;
    end else begin
      src1 <= next_src1;
      src2 <= next_src2;
      pin1_sync <= next_pin1_sync;
      pin2_sync <= next_pin2_sync;
      pin1 <= next_pin1;
      pin2 <= next_pin2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // inter-channel delay: with channel 1 also in timer mode, channel 2 timer may only start after
  // channel 1 has fired once plus the programmed delay; afterwards both run freely
  logic [DLY_W-1:0] dly, next_dly;
  logic ch2_go, next_ch2_go;
  logic ch1_trig;

  always_comb begin
    next_dly = dly;
    next_ch2_go = ch2_go;
    if (src2 != STUB_SRC_TIMER) begin
      next_ch2_go = 1'b0;
      next_dly = interchannel_trigger_delay;
    end else if (!ch2_go) begin
      if (src1 != STUB_SRC_TIMER) begin
        next_ch2_go = 1'b1;
      end else if (ch1_trig || dly != interchannel_trigger_delay) begin
        // counting starts at the channel one strobe; go and the strobe add two stages for every delay
        if (dly == '0) begin
          next_ch2_go = 1'b1;
        end else begin
          next_dly = dly - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dly <= DELAY_RESET;
      ch2_go <= 1'b0;
    end else begin
      dly <= next_dly;
      ch2_go <= next_ch2_go;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffer reset commands
  logic [1:0] buf_reset;
  always_comb begin
    buf_reset[0] = device_command_wr && (device_command_reg == CMD_RESET_CH1);
    buf_reset[1] = device_command_wr && (device_command_reg == CMD_RESET_CH2);
  end

  //////////////////////////////////////////////////////////////////////////////
  // two independent channels
  stub_channel #(.BITS(UP_BITS)) u_ch1 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .src_sel(src1),
    .encoding_method_select(encoding_method_select[0]),
    .interval(sync_interval_timer_reg_ch1),
    .spi_trig(spi_sync_cmd[0]),
    .spi_trig_long(spi_sync_long[0]),
    .pin_level(pin1),
    .delayed_start(1'b1),
    .buf_wr(upstream_wr[0]),
    .buf_wdata(upstream_wdata),
    .buf_len(upstream_len),
    .upstream_confirm(upstream_confirm[0]),
    .buf_reset(buf_reset[0]),
    .fault_clr(upstream_fault_clr[0]),
    .trig(ch1_trig),
    .trig_long(sync_trigger_long[0]),
    .in_progress(upstream_in_progress[0]),
    .fault(upstream_overrun_fault[0])
  );

  stub_channel #(.BITS(UP_BITS)) u_ch2 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .src_sel(src2),
    .encoding_method_select(encoding_method_select[1]),
    .interval(sync_interval_timer_reg_ch2),
    .spi_trig(spi_sync_cmd[1]),
    .spi_trig_long(spi_sync_long[1]),
    .pin_level(pin2),
    .delayed_start(ch2_go),
    .buf_wr(upstream_wr[1]),
    .buf_wdata(upstream_wdata),
    .buf_len(upstream_len),
    .upstream_confirm(upstream_confirm[1]),
    .buf_reset(buf_reset[1]),
    .fault_clr(upstream_fault_clr[1]),
    .trig(sync_trigger[1]),
    .trig_long(sync_trigger_long[1]),
    .in_progress(upstream_in_progress[1]),
    .fault(upstream_overrun_fault[1])
  );

  assign sync_trigger[0] = ch1_trig;
endmodule
`default_nettype wire

// *** src/stub_pkg.sv ***
/*
  Shared constants for the two-channel sync trigger and upstream buffer block.
  Assumes one 50 MHz system clock and a synchronous active-low reset.
*/
package stub_pkg;
  localparam int CLK_MHZ = 50;
  localparam int UP_BITS = 64;
  localparam int UP_CNT_W = 7;
  localparam int TMR_W = 16;
  localparam int DLY_W = 16;
  localparam logic [15:0] CMD_RESET_CH1 = 16'h00FF;
  localparam logic [15:0] CMD_RESET_CH2 = 16'hFF00;
  typedef enum logic [2:0] {
    STUB_SRC_SPI_DIRECT = 3'b000,
    STUB_SRC_SPI_BUFFER = 3'b001,
    STUB_SRC_PIN_DIRECT = 3'b010,
    STUB_SRC_PIN_BUFFER = 3'b011,
    STUB_SRC_TIMER = 3'b100
  } stub_src_t;
  localparam stub_src_t SRC_RESET = STUB_SRC_PIN_DIRECT;
  localparam logic [TMR_W-1:0] INTERVAL_RESET = 16'h0000;
  localparam logic [DLY_W-1:0] DELAY_RESET = 16'h0000;
endpackage

// *** src/stub_channel.sv ***
/*
  One channel: upstream shift buffer, trigger source selection, interval
  timer/filter and pulse shaping.
  Assumes the pin input is already synchronised and all other inputs are on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module stub_channel
  import stub_pkg::*;
#(
  parameter int BITS = UP_BITS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire stub_src_t src_sel,
  input wire logic encoding_method_select,
  input wire logic [TMR_W-1:0] interval,
  input wire logic spi_trig,
  input wire logic spi_trig_long,
  input wire logic pin_level,
  input wire logic delayed_start,
  input wire logic buf_wr,
  input wire logic [BITS-1:0] buf_wdata,
  input wire logic [UP_CNT_W-1:0] buf_len,
  input wire logic upstream_confirm,
  input wire logic buf_reset,
  input wire logic fault_clr,
  output logic trig,
  output logic trig_long,
  output logic in_progress,
  output logic fault
);
  logic [BITS-1:0] shreg, next_shreg;
  logic [UP_CNT_W-1:0] left, next_left;
  logic loaded, next_loaded;
  logic busy, next_busy;
  logic flt, next_flt;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic pin_prev, next_pin_prev;
  logic o_trig, next_o_trig, o_long, next_o_long;
  logic raw, buffered, window_open, accept, shift_bit;

  // the bit counter must be able to hold a full buffer length
  if (BITS < 1 || BITS >= (1 << UP_CNT_W)) begin : g_bits_check
    $error("BITS does not fit the bit counter");
  end

  always_comb begin
    buffered = (src_sel == STUB_SRC_SPI_BUFFER) || (src_sel == STUB_SRC_PIN_BUFFER) ||
               (src_sel == STUB_SRC_TIMER);
    window_open = (tmr == '0);
    case (src_sel)
      STUB_SRC_SPI_DIRECT, STUB_SRC_SPI_BUFFER: raw = spi_trig;
      STUB_SRC_PIN_DIRECT, STUB_SRC_PIN_BUFFER: raw = pin_level && !pin_prev;
      STUB_SRC_TIMER: raw = window_open && delayed_start;
      default: raw = 1'b0;
    endcase
    accept = raw && (window_open || src_sel == STUB_SRC_TIMER);
    shift_bit = shreg[0];
    next_shreg = shreg;
    next_left = left;
    next_loaded = loaded;
    next_busy = busy;
    next_flt = flt && !fault_clr;
    next_tmr = (tmr == '0) ? tmr : tmr - 1'b1;
    next_pin_prev = pin_level;
    next_o_trig = 1'b0;
    next_o_long = 1'b0;
    if (accept) begin
      // in timer mode the fire cycle itself counts, so the period equals the interval
      next_tmr = (src_sel == STUB_SRC_TIMER && interval != '0) ? interval - 1'b1 : interval;
      if (!buffered) begin
        next_o_trig = 1'b1;
        next_o_long = (src_sel == STUB_SRC_SPI_DIRECT) && spi_trig_long;
      end else if (busy && loaded) begin
        next_shreg = {1'b0, shreg[BITS-1:1]};
        next_left = left - 1'b1;
        if (encoding_method_select) begin
          next_o_trig = 1'b1;
          next_o_long = shift_bit;
        end else begin
          next_o_trig = shift_bit;
        end
        if (left == 7'd1) begin
          next_busy = 1'b0;
          next_loaded = 1'b0;
        end
      end else if (busy) begin
        next_flt = 1'b1; // trigger while buffer filled but unconfirmed
      end else begin
        next_o_trig = 1'b1;
      end
    end
    if (buf_wr) begin
      if (busy) begin
        next_flt = 1'b1;
      end else if (buf_len != '0) begin
        next_shreg = buf_wdata;
        next_left = buf_len;
        next_busy = 1'b1;
      end
    end
    if (upstream_confirm && busy) begin
      next_loaded = 1'b1;
    end
    if (buf_reset) begin
      next_busy = 1'b0;
      next_loaded = 1'b0;
      next_left = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      shreg <= '0;
      left <= '0;
      loaded <= 1'b0;
      busy <= 1'b0;
      flt <= 1'b0;
      tmr <= '0;
      pin_prev <= 1'b0;
      o_trig <= 1'b0;
      o_long <= 1'b0;
    end else begin
      shreg <= next_shreg;
      left <= next_left;
      loaded <= next_loaded;
      busy <= next_busy;
      flt <= next_flt;
      tmr <= next_tmr;
      pin_prev <= next_pin_prev;
      o_trig <= next_o_trig;
      o_long <= next_o_long;
    end
  end

  assign trig = o_trig;
  assign trig_long = o_long;
  assign in_progress = busy;
  assign fault = flt;
endmodule
`default_nettype wire

// *** testbench/stub_monitor.sv ***
/*
  Checker on the ports of stub_top.
  Assumes it is bound into stub_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module stub_monitor
  import stub_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [1:0] upstream_wr,
  input wire logic [stub_pkg::UP_CNT_W-1:0] upstream_len,
  input wire logic device_command_wr,
  input wire logic [15:0] device_command_reg,
  input wire logic [1:0] upstream_fault_clr,
  input wire logic [1:0] sync_trigger,
  input wire logic [1:0] sync_trigger_long,
  input wire logic [1:0] upstream_in_progress,
  input wire logic [1:0] upstream_overrun_fault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  reset_clean_a: assert property ($rose(resetn) |-> (sync_trigger | upstream_in_progress | upstream_overrun_fault) == 2'h0)
    else $error("outputs not clear after reset");
  long_qual_a: assert property ((sync_trigger_long & ~sync_trigger) == 2'h0)
    else $error("long qualifier without strobe");
  write_busy_a: assert property (upstream_wr[0] && !upstream_in_progress[0] && upstream_len != 7'h00
    && !device_command_wr |=> upstream_in_progress[0])
    else $error("write did not set busy");
  busy_wr_fault_a: assert property (upstream_wr[0] && upstream_in_progress[0] |=> upstream_overrun_fault[0])
    else $error("write while busy left fault clear ch1");
  busy_wr_fault2_a: assert property (upstream_wr[1] && upstream_in_progress[1] |=> upstream_overrun_fault[1])
    else $error("write while busy left fault clear ch2");
  fault_sticky_a: assert property (upstream_overrun_fault[0] && !upstream_fault_clr[0] && !device_command_wr
    |=> upstream_overrun_fault[0])
    else $error("fault dropped without clear");
  cmd_reset_one_a: assert property (device_command_wr && device_command_reg == CMD_RESET_CH1 && !upstream_wr[0]
    |=> !upstream_in_progress[0])
    else $error("channel one buffer not reset");
  cmd_reset_two_a: assert property (device_command_wr && device_command_reg == CMD_RESET_CH2 && !upstream_wr[1]
    |=> !upstream_in_progress[1])
    else $error("channel two buffer not reset");
  cover property (sync_trigger_long[1]);
  cover property ($fell(upstream_in_progress[0]));
  cover property ($rose(upstream_overrun_fault[0]));
endmodule
bind stub_top stub_monitor mon (.ref_clk, .resetn, .upstream_wr, .upstream_len, .device_command_wr,
  .device_command_reg, .upstream_fault_clr, .sync_trigger, .sync_trigger_long, .upstream_in_progress,
  .upstream_overrun_fault);
`default_nettype wire

// *** testbench/stub_host_pins.sv ***
/*
  Host side trigger pins: each request gives a 3-cycle high pulse.
  Assumes requests are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module stub_host_pins (
  input wire logic ref_clk,
  input wire logic [1:0] pin_req,
  output logic ext_trigger_pin_ch1,
  output logic ext_trigger_pin_ch2
);
  // short pulses only: the pin sources act on the rising edge; only the buffered pin source in pulse length mode sets the long qualifier
  logic [2:0] hold1 = 3'h0;
  logic [2:0] hold2 = 3'h0;
  always_ff @(posedge ref_clk) begin
    hold1 <= {hold1[1:0], pin_req[0]};
    hold2 <= {hold2[1:0], pin_req[1]};
  end
  assign ext_trigger_pin_ch1 = |hold1;
  assign ext_trigger_pin_ch2 = |hold2;
endmodule
`default_nettype wire

// *** testbench/tb_stub_top.sv ***
/*
  Self-checking bench for stub_top: strobes are matched against a queue.
  Assumes the host pin model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_stub_top;
  import stub_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, src_sel_wr = 1'b0, device_command_wr = 1'b0;
  stub_src_t src_sel_ch1 = STUB_SRC_PIN_DIRECT, src_sel_ch2 = STUB_SRC_PIN_DIRECT;
  logic [1:0] encoding_method_select = 2'h0, spi_sync_cmd = 2'h0, spi_sync_long = 2'h0, upstream_wr = 2'h0;
  logic [1:0] upstream_confirm = 2'h0, upstream_fault_clr = 2'h0, pin_req = 2'h0;
  logic [15:0] sync_interval_timer_reg_ch1 = 16'h0000, device_command_reg = 16'h0000;
  logic [15:0] sync_interval_timer_reg_ch2 = 16'h0000, interchannel_trigger_delay = 16'h0000;
  logic [63:0] upstream_wdata = 64'h0000_0000_0000_0000, d;
  logic [6:0] upstream_len = 7'h00;
  logic ext_trigger_pin_ch1, ext_trigger_pin_ch2, b;
  logic [1:0] sync_trigger, sync_trigger_long, upstream_in_progress, upstream_overrun_fault;
  logic [1:0] expq[$];
  int bad_count = 0, comparisons = 0, n;
  stub_top dut (.ref_clk, .resetn, .src_sel_ch1, .src_sel_ch2, .src_sel_wr, .encoding_method_select,
    .sync_interval_timer_reg_ch1, .sync_interval_timer_reg_ch2, .interchannel_trigger_delay,
    .spi_sync_cmd, .spi_sync_long, .ext_trigger_pin_ch1, .ext_trigger_pin_ch2, .upstream_wr, .upstream_wdata,
    .upstream_len, .upstream_confirm, .device_command_wr, .device_command_reg, .upstream_fault_clr,
    .sync_trigger, .sync_trigger_long, .upstream_in_progress, .upstream_overrun_fault);
  stub_host_pins host (.ref_clk, .pin_req, .ext_trigger_pin_ch1, .ext_trigger_pin_ch2);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  task set_src(input stub_src_t s1, input stub_src_t s2);
    src_sel_ch1 = s1;
    src_sel_ch2 = s2;
    src_sel_wr = 1'b1;
    tick(1);
    src_sel_wr = 1'b0;
    tick(1);
  endtask
  task trig(input int c, input logic lng);
    spi_sync_cmd[c] = 1'b1;
    spi_sync_long[c] = lng;
    tick(1);
    spi_sync_cmd = 2'h0;
    spi_sync_long = 2'h0;
    tick(3);
  endtask
  task pin(input int c);
    pin_req[c] = 1'b1;
    tick(1);
    pin_req = 2'h0;
    tick(8);
  endtask
  task load(input int c, input logic [6:0] len, input logic [63:0] data);
    upstream_wdata = data;
    upstream_len = len;
    upstream_wr[c] = 1'b1;
    tick(1);
    upstream_wr = 2'h0;
    tick(1);
  endtask
  task conf(input int c);
    upstream_confirm[c] = 1'b1;
    tick(1);
    upstream_confirm = 2'h0;
    tick(1);
  endtask
  task clr(input int c);
    upstream_fault_clr[c] = 1'b1;
    tick(1);
    upstream_fault_clr = 2'h0;
    tick(1);
  endtask
  task cmd(input logic [15:0] v);
    device_command_reg = v;
    device_command_wr = 1'b1;
    tick(1);
    device_command_wr = 1'b0;
    tick(1);
  endtask
  task drain;
    for (int i = 0; i < 60 && expq.size() > 0; i++) tick(1);
    if (expq.size() > 0) begin
      check(4'h0, 4'hF);
      finish_test;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (sync_trigger[c] === 1'b1) begin
        if (expq.size() == 0) check({2'h0, c[0], sync_trigger_long[c]}, 4'hF);
        else check({2'h0, c[0], sync_trigger_long[c]}, {2'h0, expq.pop_front()});
      end
    end
  end
  initial begin
    void'($urandom(40));
    tick(5);
    resetn = 1'b1;
    check({upstream_in_progress, upstream_overrun_fault}, 4'h0);
    // default source follows the pins on both channels
    expq.push_back(2'b00);
    pin(0);
    expq.push_back(2'b10);
    pin(1);
    set_src(STUB_SRC_SPI_DIRECT, STUB_SRC_SPI_DIRECT);
    for (int i = 0; i < 6; i++) begin
      b = 1'($urandom % 2);
      expq.push_back({i[0], b});
      trig(i % 2, b);
    end
    sync_interval_timer_reg_ch1 = 16'h000A;
    expq.push_back(2'b00);
    trig(0, 1'b0);
    trig(0, 1'b0);
    tick(10);
    expq.push_back(2'b00);
    trig(0, 1'b0);
    sync_interval_timer_reg_ch1 = 16'h0000;
    // let the running filter window expire before the buffered tests
    tick(10);
    drain;
    // channel one tooth gap with full buffer, channel two pulse length
    set_src(STUB_SRC_SPI_BUFFER, STUB_SRC_SPI_BUFFER);
    encoding_method_select = 2'b10;
    for (int c = 0; c < 2; c++) begin
      d = {$urandom, $urandom};
      n = (c == 0) ? 64 : 5;
      load(c, 7'(n), d);
      trig(c, 1'b0);
      check({upstream_in_progress[c], upstream_overrun_fault[c]}, 4'h3);
      clr(c);
      load(c, 7'h01, ~d);
      check({upstream_in_progress[c], upstream_overrun_fault[c]}, 4'h3);
      clr(c);
      conf(c);
      for (int i = 0; i < n; i++) begin
        if (c == 1 || d[i]) expq.push_back({c[0], c[0] & d[i]});
        trig(c, 1'b0);
      end
      check(upstream_in_progress[c], 4'h0);
      expq.push_back({c[0], 1'b0});
      trig(c, 1'b0);
      drain;
    end
    load(0, 7'h08, d);
    load(1, 7'h08, d);
    cmd(CMD_RESET_CH1);
    check(upstream_in_progress, 4'h2);
    cmd(CMD_RESET_CH2);
    check(upstream_in_progress, 4'h0);
    // buffered pin triggering, pulse length on channel one
    set_src(STUB_SRC_PIN_BUFFER, STUB_SRC_PIN_BUFFER);
    encoding_method_select = 2'b01;
    d = {$urandom, $urandom};
    load(0, 7'h02, d);
    conf(0);
    for (int i = 0; i < 2; i++) begin
      expq.push_back({1'b0, d[i]});
      pin(0);
    end
    check(upstream_in_progress, 4'h0);
    drain;
    // timer mode on both channels; channel two trails channel one by the delay plus two register stages
    sync_interval_timer_reg_ch1 = 16'h0014;
    sync_interval_timer_reg_ch2 = 16'h0014;
    interchannel_trigger_delay = 16'h0005;
    for (int i = 0; i < 6; i++) expq.push_back({i[0], 1'b0});
    set_src(STUB_SRC_TIMER, STUB_SRC_TIMER);
    n = -1;
    for (int i = 0; i < 200 && expq.size() > 0; i++) begin
      if (n >= 0) n++;
      if (sync_trigger[0] === 1'b1) begin
        if (n >= 0) check({3'h0, n == int'(sync_interval_timer_reg_ch1)}, 4'h1);
        n = 0;
      end
      if (sync_trigger[1] === 1'b1) check({3'h0, n == int'(interchannel_trigger_delay) + 2}, 4'h1);
      tick(1);
    end
    drain;
    finish_test;
  end
endmodule
`default_nettype wire
